// [include/modbus_params_pkg.sv]
// shared constants and carrier types for the modbus connection parameter block
package modbus_params_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_WD_ACTUAL = 16'h1020;
  localparam logic [15:0] ADDR_WD_PRESET = 16'h1120;
  localparam logic [15:0] ADDR_CONN_MODE = 16'h1130;
  localparam logic [15:0] ADDR_CONN_TIMEOUT = 16'h1131;
  localparam logic [15:0] ADDR_RESTORE_KEY_FIRST = 16'h113C;
  localparam logic [15:0] ADDR_RESTORE_KEY_SECOND = 16'h113D;
  localparam logic [15:0] ADDR_SAVE_KEY_FIRST = 16'h113E;
  localparam logic [15:0] ADDR_SAVE_KEY_SECOND = 16'h113F;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int MODE_SINGLE_BIT = 0;
  localparam int MODE_IMMEDIATE_BIT = 1;
  localparam int MODE_W = 2;
  localparam logic [15:0] WD_PRESET_RESET = 16'h0000;
  localparam logic [MODE_W-1:0] CONN_MODE_RESET = 2'h0;
  localparam logic [15:0] CONN_TIMEOUT_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // key sequences, index 0 restore, index 1 save
  // ----------------------------------------------------------------------
  localparam int N_SEQ = 2;
  localparam int SEQ_RESTORE = 0;
  localparam int SEQ_SAVE = 1;
  localparam logic [N_SEQ-1:0][15:0] SEQ_ADDR_FIRST =
    {ADDR_SAVE_KEY_FIRST, ADDR_RESTORE_KEY_FIRST};
  localparam logic [N_SEQ-1:0][15:0] SEQ_ADDR_SECOND =
    {ADDR_SAVE_KEY_SECOND, ADDR_RESTORE_KEY_SECOND};
  localparam logic [N_SEQ-1:0][15:0] SEQ_KEY_FIRST = {16'h7361, 16'h6C6F};
  localparam logic [N_SEQ-1:0][15:0] SEQ_KEY_SECOND = {16'h7665, 16'h6164};

  // ----------------------------------------------------------------------
  // exception codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] EXC_WRITE_REFUSED = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_MS = 1000;
  localparam int KEY_WINDOW_S = 30;
  localparam logic [15:0] KEY_WINDOW_MS = 16'(KEY_WINDOW_S * SEC_MS);
  localparam int LED_FLASH_HALF_MS = 250;

  // ----------------------------------------------------------------------
  // connections, outputs and saved image
  // ----------------------------------------------------------------------
  localparam int N_CONN = 4;
  localparam int CONN_W = 2;
  localparam int OUT_W = 16;
  localparam int NV_DEPTH = 4;
  localparam int NV_AW = 2;
  localparam logic [NV_AW-1:0] NV_SLOT_WD = 2'h0;
  localparam logic [NV_AW-1:0] NV_SLOT_MODE = 2'h1;
  localparam logic [NV_AW-1:0] NV_SLOT_TIMEOUT = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [CONN_W-1:0] conn;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } req_t;

  typedef struct packed {
    logic exc;
    logic [7:0] code;
    logic [15:0] rdata;
  } rsp_t;

  typedef enum logic {SAVE_IDLE, SAVE_RUN} save_state_t;

endpackage

// [rtl/nv_param_mem.sv]
// small memory holding the saved parameter image, registered read port
`timescale 1ns/1ps
`default_nettype none
module nv_param_mem (
  // clock
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [modbus_params_pkg::NV_AW-1:0] waddr,
  input wire logic [15:0] wdata,
  // read port
  input wire logic [modbus_params_pkg::NV_AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [modbus_params_pkg::NV_DEPTH];

  // contents carry no reset: they model storage that outlives the logic
  always_ff @(posedge clk_sys) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// [rtl/modbus_conn_params.sv]
// connection arbitration, timeouts, key sequences and output watchdog
`timescale 1ns/1ps
`default_nettype none
module modbus_conn_params #(
  parameter int MS_CYCLES = modbus_params_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // register request, one beat per register word
  input wire logic req_valid,
  input wire modbus_params_pkg::req_t req,
  // answer, one cycle after each beat
  output logic rsp_valid,
  output modbus_params_pkg::rsp_t rsp,
  // connection events from the tcp side
  input wire logic conn_open,
  input wire logic conn_close,
  input wire logic [modbus_params_pkg::CONN_W-1:0] conn_event_id,
  // connection state towards the tcp side
  output logic [modbus_params_pkg::N_CONN-1:0] conn_drop,
  output logic [modbus_params_pkg::N_CONN-1:0] write_grant,
  // module outputs
  input wire logic [modbus_params_pkg::OUT_W-1:0] out_image,
  output logic [modbus_params_pkg::OUT_W-1:0] module_out,
  output logic link_indicator_led,
  // saved image inspection
  input wire logic [modbus_params_pkg::NV_AW-1:0] nv_raddr,
  output logic [15:0] nv_rdata
);
  localparam int N = modbus_params_pkg::N_CONN;

  // ----------------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------------
  logic [15:0] ms_cnt, next_ms_cnt;
  logic [9:0] sec_ms_cnt, next_sec_ms_cnt;
  logic ms_tick, sec_tick;

  assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
  assign sec_tick = ms_tick &&
    (sec_ms_cnt == 10'(modbus_params_pkg::SEC_MS - 1));

  always_comb begin
    next_ms_cnt = ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
    next_sec_ms_cnt = sec_ms_cnt;
    if (sec_tick) begin
      next_sec_ms_cnt = 10'h000;
    end else if (ms_tick) begin
      next_sec_ms_cnt = sec_ms_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ms_cnt <= 16'h0000;
      sec_ms_cnt <= 10'h000;
    end else if (ce) begin
      ms_cnt <= next_ms_cnt;
      sec_ms_cnt <= next_sec_ms_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------------------
  logic [15:0] wd_preset, next_wd_preset;
  logic [modbus_params_pkg::MODE_W-1:0] conn_mode, next_conn_mode;
  logic [15:0] conn_timeout, next_conn_timeout;
  logic single_mode, immediate_mode;
  logic [modbus_params_pkg::N_SEQ-1:0] seq_fire;
  logic wr_do;

  assign single_mode = conn_mode[modbus_params_pkg::MODE_SINGLE_BIT];
  assign immediate_mode = conn_mode[modbus_params_pkg::MODE_IMMEDIATE_BIT];

  always_comb begin
    next_wd_preset = wd_preset;
    next_conn_mode = conn_mode;
    next_conn_timeout = conn_timeout;
    if (seq_fire[modbus_params_pkg::SEQ_RESTORE]) begin
      // working copy only, the saved image is untouched
      next_wd_preset = modbus_params_pkg::WD_PRESET_RESET;
      next_conn_mode = modbus_params_pkg::CONN_MODE_RESET;
      next_conn_timeout = modbus_params_pkg::CONN_TIMEOUT_RESET;
    end else if (wr_do) begin
      case (req.addr)
        modbus_params_pkg::ADDR_WD_PRESET: next_wd_preset = req.wdata;
        modbus_params_pkg::ADDR_CONN_MODE:
          next_conn_mode = req.wdata[modbus_params_pkg::MODE_W-1:0];
        modbus_params_pkg::ADDR_CONN_TIMEOUT: next_conn_timeout = req.wdata;
        default: next_wd_preset = wd_preset;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_preset <= modbus_params_pkg::WD_PRESET_RESET;
      conn_mode <= modbus_params_pkg::CONN_MODE_RESET;
      conn_timeout <= modbus_params_pkg::CONN_TIMEOUT_RESET;
    end else if (ce) begin
      wd_preset <= next_wd_preset;
      conn_mode <= next_conn_mode;
      conn_timeout <= next_conn_timeout;
    end
  end

  // ----------------------------------------------------------------------
  // write authorization and connection supervision
  // ----------------------------------------------------------------------
  logic [N-1:0] conn_active, auth, timeout_hit, wr_grant_vec;
  logic owner_taken, grant_at_open, wr_beat, wr_ok, mapped, wr_refused;

  assign owner_taken = |auth;
  // immediate mode hands out the grant while the connection comes up
  assign grant_at_open = conn_open && immediate_mode &&
    (!single_mode || !owner_taken);
  assign wr_beat = req_valid && req.write;
  // a second holder is only possible when single-writer is clear
  assign wr_ok = auth[req.conn] || !single_mode ||
    (!immediate_mode && !owner_taken && !grant_at_open);
  assign wr_refused = wr_beat && !wr_ok;
  assign wr_do = wr_beat && wr_ok && mapped &&
    (req.addr != modbus_params_pkg::ADDR_WD_ACTUAL);
  assign write_grant = auth;

  for (genvar i = 0; i < N; i++) begin : g_conn
    logic [15:0] idle_s, next_idle_s;
    logic next_active, next_auth, opened, closed, touched;

    assign opened = conn_open && (conn_event_id == CONN_W_ID(i));
    assign closed = conn_close && (conn_event_id == CONN_W_ID(i));
    assign touched = req_valid && (req.conn == CONN_W_ID(i));
    assign wr_grant_vec[i] = wr_beat && touched && !auth[i] && wr_ok;
    // zero timeout means the connection is never dropped
    assign timeout_hit[i] = conn_active[i] && (conn_timeout != 16'h0000) &&
      (idle_s >= conn_timeout);

    always_comb begin
      next_active = conn_active[i];
      next_auth = auth[i];
      next_idle_s = idle_s;
      if (opened) begin
        next_active = 1'b1;
        next_auth = grant_at_open;
      end else if (closed || timeout_hit[i]) begin
        next_active = 1'b0;
        next_auth = 1'b0;
      end else if (wr_grant_vec[i]) begin
        next_auth = 1'b1;
      end
      if (opened || touched) begin
        next_idle_s = 16'h0000;
      end else if (sec_tick && conn_active[i] && idle_s != 16'hFFFF) begin
        next_idle_s = idle_s + 16'h0001;
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        conn_active[i] <= 1'b0;
        auth[i] <= 1'b0;
        idle_s <= 16'h0000;
        conn_drop[i] <= 1'b0;
      end else if (ce) begin
        conn_active[i] <= next_active;
        auth[i] <= next_auth;
        idle_s <= next_idle_s;
        conn_drop[i] <= timeout_hit[i] && !closed;
      end
    end
  end

  function automatic logic [modbus_params_pkg::CONN_W-1:0] CONN_W_ID(
    input int idx
  );
    return idx[modbus_params_pkg::CONN_W-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // restore and save key sequences
  // ----------------------------------------------------------------------
  for (genvar s = 0; s < modbus_params_pkg::N_SEQ; s++) begin : g_seq
    logic armed, next_armed;
    logic [15:0] win_ms, next_win_ms;
    logic hit_first, hit_second, in_window;

    assign hit_first = wr_do &&
      (req.addr == modbus_params_pkg::SEQ_ADDR_FIRST[s]);
    assign hit_second = wr_do &&
      (req.addr == modbus_params_pkg::SEQ_ADDR_SECOND[s]);
    assign in_window = win_ms < modbus_params_pkg::KEY_WINDOW_MS;
    // back-to-back beats of one multi-register write arm then fire
    assign seq_fire[s] = hit_second && armed && in_window &&
      (req.wdata == modbus_params_pkg::SEQ_KEY_SECOND[s]);

    always_comb begin
      next_armed = armed;
      next_win_ms = win_ms;
      if (hit_first) begin
        next_armed = (req.wdata == modbus_params_pkg::SEQ_KEY_FIRST[s]);
        next_win_ms = 16'h0000;
      end else if (hit_second || (armed && !in_window)) begin
        // fired, wrong, or late: the sequence starts over
        next_armed = 1'b0;
      end else if (armed && ms_tick) begin
        next_win_ms = win_ms + 16'h0001;
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        armed <= 1'b0;
        win_ms <= 16'h0000;
      end else if (ce) begin
        armed <= next_armed;
        win_ms <= next_win_ms;
      end
    end
  end

  // ----------------------------------------------------------------------
  // save engine copies the three working words into the saved image
  // ----------------------------------------------------------------------
  modbus_params_pkg::save_state_t save_state, next_save_state;
  logic [modbus_params_pkg::NV_AW-1:0] save_slot, next_save_slot;
  logic nv_we;
  logic [15:0] nv_wdata;

  always_comb begin
    next_save_state = save_state;
    next_save_slot = save_slot;
    nv_we = 1'b0;
    nv_wdata = wd_preset;
    case (save_state)
      modbus_params_pkg::SAVE_IDLE: begin
        if (seq_fire[modbus_params_pkg::SEQ_SAVE]) begin
          next_save_state = modbus_params_pkg::SAVE_RUN;
          next_save_slot = modbus_params_pkg::NV_SLOT_WD;
        end
      end
      modbus_params_pkg::SAVE_RUN: begin
        nv_we = 1'b1;
        case (save_slot)
          modbus_params_pkg::NV_SLOT_MODE: nv_wdata = 16'(conn_mode);
          modbus_params_pkg::NV_SLOT_TIMEOUT: nv_wdata = conn_timeout;
          default: nv_wdata = wd_preset;
        endcase
        if (save_slot == modbus_params_pkg::NV_SLOT_TIMEOUT) begin
          next_save_state = modbus_params_pkg::SAVE_IDLE;
        end else begin
          next_save_slot = save_slot + 2'h1;
        end
      end
      default: next_save_state = modbus_params_pkg::SAVE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      save_state <= modbus_params_pkg::SAVE_IDLE;
      save_slot <= modbus_params_pkg::NV_SLOT_WD;
    end else if (ce) begin
      save_state <= next_save_state;
      save_slot <= next_save_slot;
    end
  end

  nv_param_mem u_nv (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .we(nv_we),
    .waddr(save_slot),
    .wdata(nv_wdata),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );

  // ----------------------------------------------------------------------
  // output watchdog and indicator
  // ----------------------------------------------------------------------
  logic [15:0] wd_actual, next_wd_actual;
  logic [modbus_params_pkg::OUT_W-1:0] next_module_out;
  logic [8:0] flash_ms, next_flash_ms;
  logic flash_phase, next_flash_phase, led_timeout, next_led_timeout;
  logic next_led, flash_wrap;

  assign flash_wrap = ms_tick &&
    (flash_ms == 9'(modbus_params_pkg::LED_FLASH_HALF_MS - 1));

  always_comb begin
    next_wd_actual = wd_actual;
    if (req_valid) begin
      next_wd_actual = 16'h0000;
    end else if (ms_tick && wd_actual != 16'hFFFF) begin
      next_wd_actual = wd_actual + 16'h0001;
    end
    // only clearing exists, never a substitute pattern
    if (wd_preset != 16'h0000 && wd_actual >= wd_preset) begin
      next_module_out = '0;
    end else begin
      next_module_out = out_image;
    end
    next_flash_ms = flash_wrap ? 9'h000 :
      (ms_tick ? flash_ms + 9'h001 : flash_ms);
    next_flash_phase = flash_wrap ? !flash_phase : flash_phase;
    // a timeout in the same cycle as a new connection keeps the flag
    next_led_timeout = (|timeout_hit) || (led_timeout && !conn_open);
    next_led = next_led_timeout ? next_flash_phase
      : (|conn_active);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_actual <= 16'h0000;
      module_out <= '0;
      flash_ms <= 9'h000;
      flash_phase <= 1'b0;
      led_timeout <= 1'b0;
      link_indicator_led <= 1'b0;
    end else if (ce) begin
      wd_actual <= next_wd_actual;
      module_out <= next_module_out;
      flash_ms <= next_flash_ms;
      flash_phase <= next_flash_phase;
      led_timeout <= next_led_timeout;
      link_indicator_led <= next_led;
    end
  end

  // ----------------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------------
  modbus_params_pkg::rsp_t next_rsp;

  always_comb begin
    mapped = 1'b1;
    next_rsp = '0;
    case (req.addr)
      modbus_params_pkg::ADDR_WD_ACTUAL: begin
        next_rsp.rdata = wd_actual;
        mapped = !req.write;
      end
      modbus_params_pkg::ADDR_WD_PRESET: next_rsp.rdata = wd_preset;
      modbus_params_pkg::ADDR_CONN_MODE: next_rsp.rdata = 16'(conn_mode);
      modbus_params_pkg::ADDR_CONN_TIMEOUT: next_rsp.rdata = conn_timeout;
      modbus_params_pkg::ADDR_RESTORE_KEY_FIRST,
      modbus_params_pkg::ADDR_RESTORE_KEY_SECOND,
      modbus_params_pkg::ADDR_SAVE_KEY_FIRST,
      modbus_params_pkg::ADDR_SAVE_KEY_SECOND: next_rsp.rdata = 16'h0000;
      default: mapped = 1'b0;
    endcase
    if (wr_refused) begin
      next_rsp.exc = 1'b1;
      next_rsp.code = modbus_params_pkg::EXC_WRITE_REFUSED;
      next_rsp.rdata = 16'h0000;
    end else if (!mapped) begin
      next_rsp.exc = 1'b1;
      next_rsp.code = modbus_params_pkg::EXC_BAD_ADDRESS;
      next_rsp.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else if (ce) begin
      rsp_valid <= req_valid;
      rsp <= req_valid ? next_rsp : rsp;
    end
  end
endmodule
`default_nettype wire

// [bench/modbus_conn_params_asserts.sv]
// assertion checker bound to the connection parameter block
`timescale 1ns/1ps
`default_nettype none
module modbus_conn_params_asserts #(
  parameter int MS_CYCLES = 4
) (
  // clock and register bus
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic req_valid,
  input wire modbus_params_pkg::req_t req,
  input wire logic rsp_valid,
  input wire modbus_params_pkg::rsp_t rsp,
  // connections and outputs
  input wire logic conn_open,
  input wire logic conn_close,
  input wire logic [1:0] conn_event_id,
  input wire logic [3:0] conn_drop,
  input wire logic [3:0] write_grant,
  input wire logic [15:0] out_image,
  input wire logic [15:0] module_out
);
  logic [3:0] evt_mask;
  assign evt_mask = (conn_open || conn_close) ? 4'h1 << conn_event_id : 4'h0;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  AST_RSP_AFTER_BEAT: assert property (
    req_valid && ce |=> rsp_valid) else $error("beat not answered");
  AST_RSP_NEEDS_BEAT: assert property (
    rsp_valid |-> $past(req_valid && ce)) else $error("answer without beat");
  AST_RSP_HOLDS: assert property (
    !rsp_valid |-> $stable(rsp)) else $error("answer changed while idle");
  AST_WD_READ_ONLY: assert property (
    req_valid && ce && req.write && write_grant[req.conn] &&
    req.addr == 16'h1020 |=> rsp.exc && rsp.code == 8'h02)
    else $error("watchdog time written");
  AST_WRITE_HOLDS_GRANT: assert property (
    rsp_valid && !rsp.exc && $past(req.write) |->
    write_grant[$past(req.conn)]) else $error("write done without grant");
  AST_GRANT_KEPT: assert property (
    ($past(write_grant) & ~write_grant & ~$past(evt_mask) & ~conn_drop &
    ~$past(conn_drop)) == 4'h0) else $error("grant lost while open");
  AST_DROP_PULSE: assert property (
    (conn_drop & $past(conn_drop)) == 4'h0) else $error("drop too long");
  AST_DROP_CLEARS: assert property (
    conn_drop != 4'h0 |=> (write_grant & $past(conn_drop) &
    ~$past(evt_mask)) == 4'h0) else $error("grant kept after drop");
  AST_KEY_READ_ZERO: assert property (
    req_valid && ce && !req.write && req.addr[15:2] == 14'h044F |=>
    !rsp.exc && rsp.rdata == 16'h0000) else $error("key read not zero");
  AST_OUT_SOURCE: assert property (
    module_out == 16'h0000 || module_out == $past(out_image))
    else $error("output not from image");
endmodule
bind modbus_conn_params modbus_conn_params_asserts #(
  .MS_CYCLES(MS_CYCLES)
) chk (
  .clk_sys, .nrst, .ce, .req_valid, .req, .rsp_valid, .rsp, .conn_open,
  .conn_close, .conn_event_id, .conn_drop, .write_grant, .out_image,
  .module_out
);
`default_nettype wire

// [bench/modbus_client_model.sv]
// register client model: beats, key sequences and connection events
`timescale 1ns/1ps
`default_nettype none
module modbus_client_model (
  // clock
  input wire logic clk_sys,
  // register bus
  output logic req_valid,
  output var modbus_params_pkg::req_t req,
  input wire logic rsp_valid,
  input wire modbus_params_pkg::rsp_t rsp,
  // connection events
  output logic conn_open,
  output logic conn_close,
  output logic [1:0] conn_event_id
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    conn_open = 1'b0;
    conn_close = 1'b0;
    conn_event_id = 2'h0;
  end
  // n back-to-back beats at ascending addresses, answer of the last one
  task automatic send(input logic [1:0] c, input logic w,
    input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1,
    input int n, output modbus_params_pkg::rsp_t r, output logic v);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      req_valid = 1'b1;
      req = {c, w, a + 16'(i), (i == 0) ? d0 : d1};
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    // idle lines never keep the old beat, so stale values cannot pass
    req = ~req;
    r = rsp;
    v = rsp_valid;
  endtask
  // seq 0 restore, 1 save; both words in one request or split
  task automatic keys(input int s, input bit one, input logic [15:0] k2);
    modbus_params_pkg::rsp_t r;
    logic v;
    if (one) begin
      send(2'h0, 1'b1, modbus_params_pkg::SEQ_ADDR_FIRST[s],
        modbus_params_pkg::SEQ_KEY_FIRST[s], k2, 2, r, v);
    end else begin
      send(2'h0, 1'b1, modbus_params_pkg::SEQ_ADDR_FIRST[s],
        modbus_params_pkg::SEQ_KEY_FIRST[s], 16'h0000, 1, r, v);
      repeat (5) @(negedge clk_sys);
      send(2'h0, 1'b1, modbus_params_pkg::SEQ_ADDR_SECOND[s],
        k2, 16'h0000, 1, r, v);
    end
    repeat (6) @(negedge clk_sys);
  endtask
  // one event per cycle, single id
  task automatic ev(input logic [1:0] id, input logic open);
    @(negedge clk_sys);
    conn_event_id = id;
    conn_open = open;
    conn_close = !open;
    @(negedge clk_sys);
    conn_open = 1'b0;
    conn_close = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/modbus_connection_params_tb_top.sv]
// self-checking testbench for the connection parameter block
`timescale 1ns/1ps
`default_nettype none
module modbus_connection_params_tb_top;
  localparam int MS = 4;
  logic clk_sys;
  logic nrst;
  logic req_valid;
  modbus_params_pkg::req_t req;
  logic rsp_valid;
  modbus_params_pkg::rsp_t rsp;
  logic conn_open;
  logic conn_close;
  logic [1:0] conn_event_id;
  logic [3:0] conn_drop;
  logic [3:0] write_grant;
  logic [15:0] out_image;
  logic [15:0] module_out;
  logic link_indicator_led;
  logic [1:0] nv_raddr;
  logic [15:0] nv_rdata;
  int errors;
  int samples_checked;
  modbus_conn_params #(.MS_CYCLES(MS)) dut (.clk_sys, .nrst, .ce(1'b1),
    .req_valid, .req, .rsp_valid, .rsp, .conn_open, .conn_close,
    .conn_event_id, .conn_drop, .write_grant, .out_image, .module_out,
    .link_indicator_led, .nv_raddr, .nv_rdata);
  modbus_client_model cl (.clk_sys, .req_valid, .req, .rsp_valid, .rsp,
    .conn_open, .conn_close, .conn_event_id);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----
  // helpers
  // ----
  task automatic check(input string n, input logic [31:0] s,
    input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // code 0 expects a normal answer
  task automatic op(input logic [1:0] c, input logic w,
    input logic [15:0] a, input logic [15:0] d, input logic [7:0] code,
    output logic [15:0] q);
    modbus_params_pkg::rsp_t r;
    logic v;
    cl.send(c, w, a, d, 16'h0000, 1, r, v);
    check("answer", {v, r.exc, r.code}, {1'b1, |code, code});
    q = r.rdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] q;
    op(2'h0, 1'b0, a, 16'h0000, 8'h00, q);
    check("reg", q, e);
  endtask
  task automatic nv(input logic [1:0] s, input logic [15:0] e);
    @(negedge clk_sys);
    nv_raddr = s;
    repeat (2) @(negedge clk_sys);
    check("saved", nv_rdata, e);
  endtask
  task automatic do_reset();
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    cl.ev(2'h0, 1'b1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_basic();
    logic [15:0] q;
    do_reset();
    cl.ev(2'h1, 1'b1);
    rd(16'h1120, 16'h0000);
    rd(16'h1130, 16'h0000);
    rd(16'h1131, 16'h0000);
    op(2'h0, 1'b1, 16'h1131, 16'h0000, 8'h00, q);
    op(2'h1, 1'b1, 16'h1131, 16'h0000, 8'h00, q);
    check("grant", write_grant, 4'h3);
    op(2'h1, 1'b1, 16'h1020, 16'h0001, 8'h02, q);
  endtask
  task automatic t_single();
    logic [15:0] q;
    do_reset();
    cl.ev(2'h1, 1'b1);
    op(2'h0, 1'b1, 16'h1130, 16'h0001, 8'h00, q);
    op(2'h1, 1'b1, 16'h1131, 16'h0000, 8'h01, q);
    check("grant", write_grant, 4'h1);
    cl.ev(2'h0, 1'b0);
    op(2'h1, 1'b1, 16'h1131, 16'h0000, 8'h00, q);
    check("grant", write_grant, 4'h2);
  endtask
  task automatic t_immediate();
    logic [15:0] q;
    do_reset();
    op(2'h0, 1'b1, 16'h1130, 16'h0003, 8'h00, q);
    cl.ev(2'h2, 1'b1);
    check("grant", write_grant, 4'h1);
    op(2'h2, 1'b1, 16'h1131, 16'h0000, 8'h01, q);
    cl.ev(2'h0, 1'b0);
    cl.ev(2'h3, 1'b1);
    check("grant", write_grant, 4'h8);
    op(2'h3, 1'b1, 16'h1130, 16'h0002, 8'h00, q);
    cl.ev(2'h1, 1'b1);
    check("grant", write_grant, 4'hA);
  endtask
  task automatic t_keys();
    logic [15:0] q;
    do_reset();
    op(2'h0, 1'b1, 16'h1120, 16'h0005, 8'h00, q);
    op(2'h0, 1'b1, 16'h1130, 16'h0001, 8'h00, q);
    op(2'h0, 1'b1, 16'h1131, 16'h0003, 8'h00, q);
    cl.keys(1, 1'b1, 16'h7665);
    nv(2'h0, 16'h0005);
    nv(2'h1, 16'h0001);
    nv(2'h2, 16'h0003);
    cl.keys(0, 1'b0, 16'h1234);
    rd(16'h1120, 16'h0005);
    cl.keys(0, 1'b0, 16'h6164);
    rd(16'h1120, 16'h0000);
    rd(16'h1130, 16'h0000);
    rd(16'h1131, 16'h0000);
    nv(2'h0, 16'h0005);
  endtask
  task automatic t_watchdog();
    logic [15:0] q;
    do_reset();
    out_image = 16'hA5C3;
    op(2'h0, 1'b1, 16'h1120, 16'h0002, 8'h00, q);
    check("out", module_out, 16'hA5C3);
    repeat (4 * MS) @(negedge clk_sys);
    check("out", module_out, 16'h0000);
    op(2'h0, 1'b0, 16'h1020, 16'h0000, 8'h00, q);
    check("wd", q >= 16'h0002, 1'b1);
    op(2'h0, 1'b1, 16'h1120, 16'h0000, 8'h00, q);
    out_image = 16'h5A3C;
    repeat (8 * MS) @(negedge clk_sys);
    check("out", module_out, 16'h5A3C);
  endtask
  task automatic t_timeout();
    logic [15:0] q;
    int n;
    do_reset();
    op(2'h0, 1'b1, 16'h1131, 16'h0000, 8'h00, q);
    repeat (1100 * MS) @(negedge clk_sys);
    check("grant", write_grant, 4'h1);
    op(2'h0, 1'b1, 16'h1131, 16'h0001, 8'h00, q);
    n = 0;
    while (conn_drop[0] !== 1'b1 && n < 1100 * MS) begin
      @(negedge clk_sys);
      n++;
    end
    check("drop", n < 1100 * MS, 1'b1);
    @(negedge clk_sys);
    check("grant", write_grant, 4'h0);
    n = 0;
    repeat (600 * MS) begin
      @(negedge clk_sys);
      n += int'(link_indicator_led === 1'b1);
    end
    check("flash", n > 0 && n < 600 * MS, 1'b1);
  endtask
  // ----
  // run
  // ----
  initial begin
    nrst = 1'b0;
    out_image = 16'h0000;
    nv_raddr = 2'h0;
    errors = 0;
    samples_checked = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    t_basic();
    t_single();
    t_immediate();
    t_keys();
    t_watchdog();
    t_timeout();
    stop_test();
  end
  // the whole run needs about 10600 cycles
  initial begin
    #(40000 * 50);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
